// ==== testbench.sv ====
// Self-checking bench for the vectored interrupt map over APB.
// Assumes vipm_ctrl and vipm_core_model are compiled before it.
`timescale 1ns/1ps

module testbench;
  // Register byte addresses
  localparam logic [7:0] a_en0 = 8'h00, a_pr0 = 8'h04, a_en1 = 8'h08, a_en2 = 8'h0c;
  localparam logic [7:0] a_pr1 = 8'h10, a_pr2 = 8'h14, a_pend = 8'h18, a_stat = 8'h20;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        pin0_n, pin1_n, irq_ack, irq_done, irq_req, irq_high;
  logic [7:0]  paddr, svc_len;
  logic [31:0] pwdata, prdata, rd;
  logic [21:0] src_event;
  logic [4:0]  irq_source, k;
  logic [15:0] irq_vector;
  logic [3:0]  ack_dly;
  logic [31:0] taken[$];
  int          n_mismatch, n_tests;
  // Listed sources: fixed order and expected vector
  logic [4:0]  ord [10] = '{5'h00, 5'h02, 5'h05, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0f, 5'h11, 5'h15};
  logic [15:0] vec [10] = '{16'h0003, 16'h0013, 16'h002b, 16'h0053, 16'h005b, 16'h0063, 16'h006b,
                            16'h007b, 16'h008b, 16'h00ab};

  vipm_ctrl i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pin_irq_zero_n(pin0_n), .ext_pin_irq_one_n(pin1_n), .src_event(src_event),
    .irq_ack(irq_ack), .irq_done(irq_done), .irq_req(irq_req), .irq_high(irq_high),
    .irq_source(irq_source), .irq_vector(irq_vector));

  vipm_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_ack(irq_ack),
    .irq_done(irq_done), .ack_dly(ack_dly), .svc_len(svc_len));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Log every vector the core really takes
  always @(posedge pclk) begin
    if (presetn && irq_ack === 1'b1 && irq_req === 1'b1) taken.push_back({10'h000, irq_high, irq_source, irq_vector});
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error land in rd and err
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_mismatch++; // Bus answer never came
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  // Falling edge on one of the two pins, held low two cycles
  task pin_edge(input logic one);
    @(posedge pclk);
    if (one) pin1_n <= 1'b0;
    else pin0_n <= 1'b0;
    repeat (2) @(posedge pclk);
    pin0_n <= 1'b1;
    pin1_n <= 1'b1;
  endtask

  task pulse(input logic [21:0] m);
    @(posedge pclk);
    src_event <= m;
    @(posedge pclk);
    src_event <= 22'h0;
  endtask

  // Wait for the core to take a vector, then compare it
  task take(input logic [31:0] exp);
    int n;
    n = 0;
    while (taken.size() == 0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(taken.size() > 0 ? taken.pop_front() : 32'hffffffff, exp);
  endtask

  // Poll the status word until no level is in service
  task idle;
    int n;
    n = 0;
    do begin
      apb(a_stat, 1'b0, 32'h0);
      n++;
    end while (rd[9:8] !== 2'b00 && n < 60);
    if (rd[9:8] !== 2'b00) n_mismatch++; // Handler never returned
  endtask

  // Enable (pri=0) or priority (pri=1) address and bit of a source
  function automatic logic [7:0] grp_a(input logic [4:0] s, input logic pri);
    if (s < 5'h06) return pri ? a_pr0 : a_en0;
    if (s < 5'h0e) return pri ? a_pr1 : a_en1;
    return pri ? a_pr2 : a_en2;
  endfunction

  function automatic logic [7:0] grp_b(input logic [4:0] s);
    if (s < 5'h06) return 8'h01 << s;
    if (s < 5'h0e) return 8'h01 << (s - 5'h06);
    return 8'h01 << (s - 5'h0e);
  endfunction

  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, src_event} = '0;
    {pin0_n, pin1_n} = 2'b11;
    ack_dly = 4'h0;
    svc_len = 8'h28;
    n_mismatch = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    chk({15'h0, irq_req, irq_vector}, 32'h0);
    presetn <= 1'b1;
    // Reset values, an unmapped address, a readback
    for (int a = 0; a < 9; a++) rchk(8'(a * 4), 32'h0);
    apb(8'h24, 1'b0, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(a_en1, 1'b1, 32'h5a);
    rchk(a_en1, 32'h5a);
    // Each source alone: gated, then enabled at alternating levels
    for (int i = 0; i < 10; i++) begin
      k = ord[i];
      apb(a_en0, 1'b1, 32'h80);
      apb(a_en1, 1'b1, 32'h0);
      if (k == 5'h00) pin_edge(1'b0);
      else if (k == 5'h02) pin_edge(1'b1);
      else pulse(22'h1 << k);
      repeat (6) @(posedge pclk);
      chk({31'h0, irq_req}, 32'h0);
      apb(grp_a(k, 1'b1), 1'b1, {24'h0, i[0] ? grp_b(k) : 8'h00});
      apb(grp_a(k, 1'b0), 1'b1, {24'h0, grp_b(k) | (k < 5'h06 ? 8'h80 : 8'h00)});
      take({10'h0, i[0], k, vec[i]});
      rchk(a_pend, k < 5'h04 ? 32'h0 : 32'h1 << k);
      apb(a_pend, 1'b1, 32'h1 << k);
      apb(grp_a(k, 1'b0), 1'b1, 32'h0);
      apb(grp_a(k, 1'b1), 1'b1, 32'h0);
      idle;
    end
    // All pending at once, the last one at high level, slow core
    ack_dly <= 4'h2;
    apb(a_en0, 1'b1, 32'h25);
    apb(a_en1, 1'b1, 32'hf0);
    apb(a_en2, 1'b1, 32'h8a);
    apb(a_pr2, 1'b1, 32'h80);
    pulse(22'h22bc25);
    rchk(a_pend, 32'h0022bc25);
    apb(a_en0, 1'b1, 32'ha5);
    take({10'h0, 1'b1, 5'h15, 16'h00ab});
    apb(a_pend, 1'b1, 32'h00200000);
    for (int i = 0; i < 9; i++) begin
      take({10'h0, 1'b0, ord[i], vec[i]});
      apb(a_pend, 1'b1, 32'h1 << ord[i]);
    end
    // Reset while a request stands
    idle;
    ack_dly <= 4'hf;
    pulse(22'h000020);
    repeat (3) @(posedge pclk);
    chk({15'h0, irq_req, irq_vector}, 32'h0001002b);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({15'h0, irq_req, irq_vector}, 32'h0);
    presetn <= 1'b1;
    rchk(a_pend, 32'h0);
    rchk(a_en0, 32'h0);
    give_verdict;
  end
endmodule

// ==== vipm_core_model.sv ====
// Behavioural core: takes offered vectors and returns from its handlers.
// Drives one-cycle ack and done pulses to the controller; pace set by the bench.
`timescale 1ns/1ps

module vipm_core_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Controller side
  input  wire logic       irq_req,
  output logic            irq_ack,
  output logic            irq_done,
  // Pace chosen by the bench
  input  wire logic [3:0] ack_dly,
  input  wire logic [7:0] svc_len
);
  logic [3:0] wait_cnt;
  logic [7:0] svc_cnt;
  logic [3:0] depth;
  logic       fin;

  // Innermost handler has run its length; never returns in an ack cycle
  assign fin = depth != 4'h0 && svc_cnt == svc_len && !irq_ack;

  // Ack after the chosen delay, count nesting, pulse done on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack  <= 1'b0;
      irq_done <= 1'b0;
      wait_cnt <= 4'h0;
      svc_cnt  <= 8'h00;
      depth    <= 4'h0;
    end else begin
      irq_ack  <= 1'b0;
      irq_done <= 1'b0;
      if (irq_ack) begin
        wait_cnt <= 4'h0;
        if (irq_req) begin
          depth   <= depth + 4'h1;
          svc_cnt <= 8'h00;
        end
      end else if (irq_req && !fin) begin
        if (wait_cnt >= ack_dly) irq_ack <= 1'b1;
        else wait_cnt <= wait_cnt + 4'h1;
      end else if (!irq_req) begin
        wait_cnt <= 4'h0;
      end
      if (fin) begin
        irq_done <= 1'b1;
        depth    <= depth - 4'h1;
        svc_cnt  <= 8'h00;
      end else if (depth != 4'h0 && !irq_ack) begin
        svc_cnt <= svc_cnt + 8'h01;
      end
    end
  end
endmodule

// ==== vipm_ctrl.sv ====
// Vectored interrupt controller with APB registers and a core handshake.
// Assumes pclk at 250 MHz, APB master in the same domain, one-cycle event pulses.
`timescale 1ns/1ps
`include "vipm_defines.svh"

// Overview of operation
// - External pin zero vectors to 0x0003, order 0, flag cleared on acceptance.
// - External pin one vectors to 0x0013, order 2, flag cleared on acceptance.
// - Timer two overflow or capture vectors to 0x002B, order 5.
// - Comparator A falling edge vectors to 0x0053, order 10.
// - Comparator A rising edge vectors to 0x005B, order 11.
// - Comparator B falling edge vectors to 0x0063, order 12.
// - Comparator B rising edge vectors to 0x006B, order 13.
// - Converter A done vectors to 0x007B, order 15.
// - Converter B done vectors to 0x008B, order 17.
// - Oscillator ready vectors to 0x00AB, order 21, the lowest.
// - Priority bit one means high level, zero means low level.
module vipm_ctrl #(
  parameter int ADDR_W = 8,
  parameter int NSRC   = 22
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt sources
  input  wire logic              ext_pin_irq_zero_n,
  input  wire logic              ext_pin_irq_one_n,
  input  wire logic [NSRC-1:0]   src_event,
  // Core handshake
  input  wire logic              irq_ack,
  input  wire logic              irq_done,
  output logic                   irq_req,
  output logic                   irq_high,
  output logic [4:0]             irq_source,
  output logic [15:0]            irq_vector
);

  initial begin
    if (NSRC != 22 || ADDR_W < 6) begin
      $error("vipm_ctrl: NSRC must be 22 and ADDR_W at least 6");
    end
  end

  vipm_pkg::vipm_state_t s_reg;
  vipm_pkg::vipm_state_t s_next;

  logic [NSRC-1:0] en;
  logic [NSRC-1:0] prio;
  logic [NSRC-1:0] act;
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] lo_req;
  logic [NSRC-1:0] sel_set;
  logic            pk_valid;
  logic            pk_hi;
  logic [4:0]      pk_idx;
  logic            allowed;
  logic [NSRC-1:0] set_ev;
  logic [NSRC-1:0] clr_ev;
  logic            acc;
  logic            commit;
  logic            taken;

  // Vector address of a fixed order
  function automatic logic [15:0] vec_of(input logic [4:0] ord);
    return `VIPM_VEC_BASE + (16'(ord) * `VIPM_VEC_STEP);
  endfunction

  // One-hot mask of a source
  function automatic logic [NSRC-1:0] bit_of(input logic [4:0] ord);
    return NSRC'(1) << ord;
  endfunction

  // Mask of all orders smaller than the given one
  function automatic logic [NSRC-1:0] below(input logic [4:0] ord);
    return bit_of(ord) - NSRC'(1);
  endfunction

  // Register offset match
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  // Enable, priority and qualified requests in fixed order
  always_comb begin
    en      = {s_reg.en2, s_reg.en1, s_reg.en0[5:0]} & {NSRC{s_reg.en0[`VIPM_EN_GLOBAL]}};
    prio    = {s_reg.pr2, s_reg.pr1, s_reg.pr0[5:0]};
    act     = s_reg.pend & en;
    hi_req  = act & prio;
    lo_req  = act & ~prio;
    sel_set = pk_hi ? hi_req : lo_req;
  end

  vipm_picker #(
    .N (NSRC)
  ) u_picker (
    .req_hi (hi_req),
    .req_lo (lo_req),
    .valid  (pk_valid),
    .sel_hi (pk_hi),
    .idx    (pk_idx)
  );

  // Next state
  always_comb begin
    s_next  = s_reg;
    acc     = psel && penable;
    commit  = acc && s_reg.pready;
    taken   = irq_ack && s_reg.req;
    // Only a high request may preempt a low one in service
    case (s_reg.svc)
      vipm_pkg::SVC_IDLE: allowed = pk_valid;
      vipm_pkg::SVC_LOW:  allowed = pk_valid && pk_hi;
      vipm_pkg::SVC_HIGH: allowed = 1'b0;
      vipm_pkg::SVC_BOTH: allowed = 1'b0;
      default:            allowed = 1'b0;
    endcase
    // Pin falling edges and peripheral events; set beats clear
    s_next.pin0_q = ext_pin_irq_zero_n;
    s_next.pin1_q = ext_pin_irq_one_n;
    set_ev = src_event;
    set_ev[`VIPM_ORD_EXT0] = src_event[`VIPM_ORD_EXT0] | (s_reg.pin0_q & ~ext_pin_irq_zero_n);
    set_ev[`VIPM_ORD_EXT1] = src_event[`VIPM_ORD_EXT1] | (s_reg.pin1_q & ~ext_pin_irq_one_n);
    clr_ev = '0;
    if (taken) begin
      clr_ev = bit_of(s_reg.src) & `VIPM_HW_CLEAR;
    end
    // Register writes at the completing edge
    if (commit && pwrite) begin
      if (hit(paddr, `VIPM_OFF_EN0)) begin
        s_next.en0 = pwdata[7:0];
      end
      if (hit(paddr, `VIPM_OFF_PR0)) begin
        s_next.pr0 = pwdata[7:0];
      end
      if (hit(paddr, `VIPM_OFF_EN1)) begin
        s_next.en1 = pwdata[7:0];
      end
      if (hit(paddr, `VIPM_OFF_EN2)) begin
        s_next.en2 = pwdata[7:0];
      end
      if (hit(paddr, `VIPM_OFF_PR1)) begin
        s_next.pr1 = pwdata[7:0];
      end
      if (hit(paddr, `VIPM_OFF_PR2)) begin
        s_next.pr2 = pwdata[7:0];
      end
      if (hit(paddr, `VIPM_OFF_PEND)) begin
        clr_ev = clr_ev | pwdata[NSRC-1:0];
      end
      if (hit(paddr, `VIPM_OFF_PSET)) begin
        set_ev = set_ev | pwdata[NSRC-1:0];
      end
    end
    s_next.pend = (s_reg.pend & ~clr_ev) | set_ev;
    // In-service tracking
    if (taken) begin
      case (s_reg.svc)
        vipm_pkg::SVC_IDLE: s_next.svc = s_reg.hi ? vipm_pkg::SVC_HIGH : vipm_pkg::SVC_LOW;
        vipm_pkg::SVC_LOW:  s_next.svc = vipm_pkg::SVC_BOTH;
        default:            s_next.svc = s_reg.svc;
      endcase
    end else if (irq_done) begin
      case (s_reg.svc)
        vipm_pkg::SVC_BOTH: s_next.svc = vipm_pkg::SVC_LOW;
        vipm_pkg::SVC_HIGH: s_next.svc = vipm_pkg::SVC_IDLE;
        vipm_pkg::SVC_LOW:  s_next.svc = vipm_pkg::SVC_IDLE;
        default:            s_next.svc = vipm_pkg::SVC_IDLE;
      endcase
    end
    // Request toward the core, dropped for a cycle after acceptance
    s_next.req = allowed && !taken && !irq_done;
    if (allowed) begin
      s_next.hi  = pk_hi;
      s_next.src = pk_idx;
      s_next.vec = vec_of(pk_idx);
    end
    // APB: one wait cycle, read data and error stand with pready
    s_next.pready  = acc && !s_reg.pready;
    s_next.pslverr = 1'b0;
    s_next.prdata  = '0;
    if (acc && !s_reg.pready) begin
      if (hit(paddr, `VIPM_OFF_EN0)) begin
        s_next.prdata = {24'h000000, s_reg.en0};
      end else if (hit(paddr, `VIPM_OFF_PR0)) begin
        s_next.prdata = {24'h000000, s_reg.pr0};
      end else if (hit(paddr, `VIPM_OFF_EN1)) begin
        s_next.prdata = {24'h000000, s_reg.en1};
      end else if (hit(paddr, `VIPM_OFF_EN2)) begin
        s_next.prdata = {24'h000000, s_reg.en2};
      end else if (hit(paddr, `VIPM_OFF_PR1)) begin
        s_next.prdata = {24'h000000, s_reg.pr1};
      end else if (hit(paddr, `VIPM_OFF_PR2)) begin
        s_next.prdata = {24'h000000, s_reg.pr2};
      end else if (hit(paddr, `VIPM_OFF_PEND)) begin
        s_next.prdata = {10'h000, s_reg.pend};
      end else if (hit(paddr, `VIPM_OFF_PSET)) begin
        s_next.prdata = '0;
      end else if (hit(paddr, `VIPM_OFF_STAT)) begin
        s_next.prdata[`VIPM_STAT_REQ]        = s_reg.req;
        s_next.prdata[`VIPM_STAT_HIGH]       = s_reg.hi;
        s_next.prdata[`VIPM_STAT_SRC +: 5]   = s_reg.src;
        s_next.prdata[`VIPM_STAT_SVC +: 2]   = s_reg.svc;
        s_next.prdata[`VIPM_STAT_VEC +: 16]  = s_reg.vec;
      end else begin
        s_next.pslverr = 1'b1;
      end
    end
  end

  // State register; reset holds vector zero and no request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.en0     <= `VIPM_RST_BYTE;
      s_reg.pr0     <= `VIPM_RST_BYTE;
      s_reg.en1     <= `VIPM_RST_BYTE;
      s_reg.en2     <= `VIPM_RST_BYTE;
      s_reg.pr1     <= `VIPM_RST_BYTE;
      s_reg.pr2     <= `VIPM_RST_BYTE;
      s_reg.pend    <= `VIPM_RST_PEND;
      s_reg.svc     <= vipm_pkg::SVC_IDLE;
      s_reg.req     <= 1'b0;
      s_reg.hi      <= 1'b0;
      s_reg.src     <= 5'h00;
      s_reg.vec     <= `VIPM_RST_VEC;
      s_reg.pin0_q  <= 1'b1;
      s_reg.pin1_q  <= 1'b1;
      s_reg.pready  <= 1'b0;
      s_reg.pslverr <= 1'b0;
      s_reg.prdata  <= 32'h00000000;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign prdata     = s_reg.prdata;
  assign pready     = s_reg.pready;
  assign pslverr    = s_reg.pslverr;
  assign irq_req    = s_reg.req;
  assign irq_high   = s_reg.hi;
  assign irq_source = s_reg.src;
  assign irq_vector = s_reg.vec;

  // Vector checks per listed source, then flag clear, level, order and reset checks
  ext0_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_EXT0) |-> s_reg.vec == `VIPM_VEC_EXT0 && $past(act[0]))
    else $error("ext pin zero vector wrong");
  ext0_hwclear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (taken && s_reg.src == `VIPM_ORD_EXT0 && !set_ev[0]) |=> !s_reg.pend[0])
    else $error("ext pin zero flag not cleared on acceptance");
  ext1_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_EXT1) |-> s_reg.vec == `VIPM_VEC_EXT1 && $past(act[2]))
    else $error("ext pin one vector wrong");
  tmr2_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_TMR2) |-> s_reg.vec == `VIPM_VEC_TMR2 && $past(act[5]))
    else $error("timer two vector wrong");
  cmpa_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_CMPA_F) |-> s_reg.vec == `VIPM_VEC_CMPA_F && $past(act[10]))
    else $error("comparator A fall vector wrong");
  cmpa_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_CMPA_R) |-> s_reg.vec == `VIPM_VEC_CMPA_R && $past(act[11]))
    else $error("comparator A rise vector wrong");
  cmpb_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_CMPB_F) |-> s_reg.vec == `VIPM_VEC_CMPB_F && $past(act[12]))
    else $error("comparator B fall vector wrong");
  cmpb_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_CMPB_R) |-> s_reg.vec == `VIPM_VEC_CMPB_R && $past(act[13]))
    else $error("comparator B rise vector wrong");
  conva_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_CONVA) |-> s_reg.vec == `VIPM_VEC_CONVA && $past(act[15]))
    else $error("converter A vector wrong");
  convb_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_CONVB) |-> s_reg.vec == `VIPM_VEC_CONVB && $past(act[17]))
    else $error("converter B vector wrong");
  osc_vector_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.req && s_reg.src == `VIPM_ORD_OSC) |-> s_reg.vec == `VIPM_VEC_OSC && $past(act[21]))
    else $error("oscillator ready vector wrong");
  level_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.req |-> s_reg.hi == $past(pk_hi) && (s_reg.hi || $past(hi_req) == '0))
    else $error("request level does not follow priority bit");
  order_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.req |-> ($past(sel_set) & below(s_reg.src)) == '0 && !(s_reg.svc == vipm_pkg::SVC_LOW && !s_reg.hi))
    else $error("smaller order or level rule skipped");
  reset_top_a: assert property (@(posedge pclk)
    $rose(presetn) |-> s_reg.vec == `VIPM_RST_VEC && !s_reg.req ##1 !s_reg.req)
    else $error("reset does not hold vector zero");

endmodule

// ==== vipm_defines.svh ====
// Offsets, field positions, reset values and vector figures of the interrupt map.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef VIPM_DEFINES_SVH
`define VIPM_DEFINES_SVH

// Register byte offsets on the APB window
`define VIPM_OFF_EN0      8'h00
`define VIPM_OFF_PR0      8'h04
`define VIPM_OFF_EN1      8'h08
`define VIPM_OFF_EN2      8'h0c
`define VIPM_OFF_PR1      8'h10
`define VIPM_OFF_PR2      8'h14
`define VIPM_OFF_PEND     8'h18
`define VIPM_OFF_PSET     8'h1c
`define VIPM_OFF_STAT     8'h20

// Reset values
`define VIPM_RST_BYTE     8'h00
`define VIPM_RST_PEND     22'h000000
`define VIPM_RST_VEC      16'h0000

// Field positions
`define VIPM_EN_GLOBAL    7
`define VIPM_STAT_REQ     0
`define VIPM_STAT_HIGH    1
`define VIPM_STAT_SRC     2
`define VIPM_STAT_SVC     8
`define VIPM_STAT_VEC     16

// Vector arithmetic: vector = base + step * order
`define VIPM_VEC_BASE     16'h0003
`define VIPM_VEC_STEP     16'h0008

// Fixed orders of the listed sources
`define VIPM_ORD_EXT0     5'h00
`define VIPM_ORD_EXT1     5'h02
`define VIPM_ORD_TMR2     5'h05
`define VIPM_ORD_CMPA_F   5'h0a
`define VIPM_ORD_CMPA_R   5'h0b
`define VIPM_ORD_CMPB_F   5'h0c
`define VIPM_ORD_CMPB_R   5'h0d
`define VIPM_ORD_CONVA    5'h0f
`define VIPM_ORD_CONVB    5'h11
`define VIPM_ORD_OSC      5'h15

// Vectors of the listed sources
`define VIPM_VEC_EXT0     16'h0003
`define VIPM_VEC_EXT1     16'h0013
`define VIPM_VEC_TMR2     16'h002b
`define VIPM_VEC_CMPA_F   16'h0053
`define VIPM_VEC_CMPA_R   16'h005b
`define VIPM_VEC_CMPB_F   16'h0063
`define VIPM_VEC_CMPB_R   16'h006b
`define VIPM_VEC_CONVA    16'h007b
`define VIPM_VEC_CONVB    16'h008b
`define VIPM_VEC_OSC      16'h00ab

// Sources whose flag hardware clears when the core takes the vector
`define VIPM_HW_CLEAR     22'h00000f

`endif

// ==== vipm_picker.sv ====
// Fixed-order picker: lowest set index, high level ahead of low level.
// Assumes qualified request vectors; purely combinational.
`timescale 1ns/1ps

module vipm_picker #(
  parameter int N = 22
) (
  // Qualified requests per level
  input  wire logic [N-1:0] req_hi,
  input  wire logic [N-1:0] req_lo,
  // Selection
  output logic              valid,
  output logic              sel_hi,
  output logic [4:0]        idx
);

  initial begin
    if (N < 1 || N > 32) begin
      $error("vipm_picker: N out of range");
    end
  end

  // Index of the lowest set bit
  function automatic logic [4:0] first_set(input logic [N-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // High level wins, then smallest order
  always_comb begin
    valid  = |req_hi || |req_lo;
    sel_hi = |req_hi;
    idx    = sel_hi ? first_set(req_hi) : first_set(req_lo);
  end

endmodule

// ==== vipm_pkg.sv ====
// Types shared by the interrupt map modules.
// Assumes vipm_defines.svh is on the include path.
`include "vipm_defines.svh"

package vipm_pkg;

  // In-service state of the two priority levels
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_LOW  = 2'b01,
    SVC_HIGH = 2'b10,
    SVC_BOTH = 2'b11
  } vipm_svc_t;

  // Whole state of the controller
  typedef struct packed {
    logic [7:0]  en0;
    logic [7:0]  pr0;
    logic [7:0]  en1;
    logic [7:0]  en2;
    logic [7:0]  pr1;
    logic [7:0]  pr2;
    logic [21:0] pend;
    vipm_svc_t   svc;
    logic        req;
    logic        hi;
    logic [4:0]  src;
    logic [15:0] vec;
    logic        pin0_q;
    logic        pin1_q;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } vipm_state_t;

endpackage
